// ---- adc_seq_pkg.sv ----
// Notes on behaviour
// - only falling trigger edges count; edge bits 00
// - select mode converts one lower channel; 1-buffer stores it in the matching slot
// - 1-buffer: one conversion, done pulse, then wait
// - run bit high: every valid trigger starts a conversion
// - 4-buffer: four triggers fill slots 0-3, done
// - scan walks lower channels from 0, one per trigger
// - lower-only scan ends with done pulse, stops
// - upper channels follow without waiting for triggers
// - scan end pulses done; next trigger restarts
// - clearing run aborts conversion, nothing stored
// - simultaneous triggers: lowest taken, rest not counted
// - timer trigger mid-conversion aborts and restarts fresh, except on back-to-back upper channels
// - aborting trigger still counted; cut-off value dropped, even in the finishing cycle
// - halt keeps converting; registers hold contents
// - idle/stop gate clock; software clears run first
// - compare match starts conversion regardless of cpu mask
// - trigger pin shared; function bit routes it here
package adc_seq_pkg;

  // register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_MODE_FIRST = 8'h00;
  localparam logic [7:0] OFS_MODE_SECOND = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PORT_MODE = 8'h0c;
  localparam logic [7:0] OFS_EXT_IRQ_MODE = 8'h10;
  localparam logic [2:0] RESULT_PAGE = 3'h1; // results at 0x20..0x3c

  // trigger source codes
  localparam logic [2:0] TRG_SRC_EXT = 3'h6;
  localparam logic [2:0] TRG_SRC_TIMER = 3'h2;
  localparam logic [1:0] EDGE_FALLING = 2'h0;

  // channel layout and timing
  localparam int NUM_CHANS = 8;
  localparam logic [2:0] LAST_LOWER = 3'h3;
  localparam logic [2:0] LAST_BUF = 3'h3;
  localparam int CONV_STEP_CYCLES = 8; // cycles per conversion-time step
  localparam int CNT_W = 8;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // first mode register fields
  typedef struct packed {
    logic run;
    logic scan;
    logic buf4;
    logic [1:0] rsv;
    logic [2:0] chan;
  } mode_first_t;

  // second mode register fields
  typedef struct packed {
    logic rsv1;
    logic [2:0] trg;
    logic rsv0;
    logic [2:0] fr;
  } mode_second_t;

  localparam mode_first_t MODE_FIRST_RST = 8'h00;
  localparam mode_second_t MODE_SECOND_RST = 8'h00;

  // sequencer states, gray along idle -> wait -> convert
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CONV = 2'b11
  } seq_state_t;

endpackage

// ---- adc_ext_trigger_seq.sv ----
`timescale 1ns/100ps
`default_nettype none
module adc_ext_trigger_seq #(
  parameter int RES_W = 10
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [adc_seq_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [adc_seq_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic ext_conv_trigger_pin_i,
  input wire logic [3:0] timer_match_i,
  input wire logic [RES_W-1:0] adc_data_i,
  output logic [2:0] analog_channel_input_sel_o,
  output logic conv_busy_o,
  output logic conv_done_irq_o
);
  import adc_seq_pkg::*;

  // refuse result widths outside 1 to 16 bits
  if (RES_W < 1 || RES_W > 16) begin : g_bad_width
    $error("RES_W must lie between 1 and 16");
  end

  // bus-side state
  logic aw_hold_q; // write address captured
  logic w_hold_q; // write data captured
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic wr_fire; // both halves present, write happens now
  logic wr_hit; // write address is mapped

  // software-visible configuration
  mode_first_t mode_first_q;
  mode_second_t mode_second_q;
  logic port_fn_q; // trig_pin_function_bit
  logic [1:0] edge_sel_q; // edge_select_bit_hi, edge_select_bit_lo

  // sequencer state
  seq_state_t state_q;
  logic [2:0] step_q; // result slot or scan channel
  logic soft_q; // upper channels run without triggers
  logic [CNT_W-1:0] cnt_q; // cycles left in conversion
  logic irq_q;
  logic [2:0] chan_sel_q;
  logic pin_q; // previous trigger pin level
  logic [RES_W-1:0] result_q [NUM_CHANS];

  // combinational helpers
  logic run_clr; // software is clearing run this cycle
  logic ext_trig;
  logic timer_trig;
  logic trig;
  logic conv_done;
  logic [CNT_W-1:0] conv_len;
  logic [2:0] cur_chan;
  logic [2:0] slot;
  logic last_step;
  logic [2:0] next_step;

  // ---------------- AXI4-Lite write path ----------------
  // one write in flight: both channels stall while the answer stands
  assign s_axi_awready_o = !aw_hold_q && !bvalid_q;
  assign s_axi_wready_o = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign wr_fire = aw_hold_q && w_hold_q;
  assign wr_hit = (awaddr_q == OFS_MODE_FIRST) || (awaddr_q == OFS_MODE_SECOND) ||
                  (awaddr_q == OFS_PORT_MODE) || (awaddr_q == OFS_EXT_IRQ_MODE) ||
                  (awaddr_q == OFS_STATUS) || (awaddr_q[7:5] == RESULT_PAGE && awaddr_q[1:0] == 2'h0);

  // address and data taken in either order, answer after both
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        // halves released in the same edge the answer rises
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready_i) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // configuration registers, low byte only
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mode_first_q <= MODE_FIRST_RST;
      mode_second_q <= MODE_SECOND_RST;
      port_fn_q <= 1'b0;
      edge_sel_q <= EDGE_FALLING;
    end else if (wr_fire && wstrb_q[0]) begin
      // contents survive anything but reset, standby included
      unique case (awaddr_q)
        OFS_MODE_FIRST: mode_first_q <= wdata_q[7:0];
        OFS_MODE_SECOND: mode_second_q <= wdata_q[7:0];
        OFS_PORT_MODE: port_fn_q <= wdata_q[0];
        OFS_EXT_IRQ_MODE: edge_sel_q <= wdata_q[1:0];
        default: ; // status and results are read-only
      endcase
    end
  end

  // ---------------- AXI4-Lite read path ----------------
  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;

  // answer one cycle after the address is taken
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
      if (s_axi_araddr_i[7:5] == RESULT_PAGE && s_axi_araddr_i[1:0] == 2'h0) begin
        rdata_q[RES_W-1:0] <= result_q[s_axi_araddr_i[4:2]];
      end else begin
        unique case (s_axi_araddr_i)
          OFS_MODE_FIRST: rdata_q[7:0] <= mode_first_q;
          OFS_MODE_SECOND: rdata_q[7:0] <= mode_second_q;
          // live sequencer state and the registered pin level
          OFS_STATUS: rdata_q[5:0] <= {pin_q, soft_q, conv_busy_o, step_q};
          OFS_PORT_MODE: rdata_q[0] <= port_fn_q;
          OFS_EXT_IRQ_MODE: rdata_q[1:0] <= edge_sel_q;
          default: rresp_q <= RESP_SLVERR; // unmapped, data zero
        endcase
      end
    end else if (rvalid_q && s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------- trigger front end ----------------
  // previous pin level for edge detection
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= ext_conv_trigger_pin_i;
    end
  end

  // falling edges only, and only when the pin is routed here
  assign ext_trig = pin_q && !ext_conv_trigger_pin_i && port_fn_q &&
                    (mode_second_q.trg == TRG_SRC_EXT);
  // any compare match starts, whatever the cpu mask says
  // coincident matches collapse to one trigger, counted once
  assign timer_trig = (|timer_match_i) && (mode_second_q.trg == TRG_SRC_TIMER);
  assign trig = ext_trig || timer_trig;

  // software clearing run must win even in the finishing cycle
  assign run_clr = wr_fire && wstrb_q[0] && (awaddr_q == OFS_MODE_FIRST) && !wdata_q[7];

  // conversion length scales with the conversion time field
  assign conv_len = CNT_W'((32'(mode_second_q.fr) + 32'd1) * CONV_STEP_CYCLES);

  // select mode pins one lower channel; scan walks the step
  assign cur_chan = mode_first_q.scan ? step_q : {1'b0, mode_first_q.chan[1:0]};
  assign slot = (mode_first_q.scan || mode_first_q.buf4) ? step_q : cur_chan;
  assign last_step = mode_first_q.scan ? (step_q == mode_first_q.chan) :
                     mode_first_q.buf4 ? (step_q == LAST_BUF) : 1'b1;
  assign next_step = last_step ? 3'h0 : step_q + 3'h1;
  // back-to-back upper channels ignore timer matches, so such a match must not stall their finish
  assign conv_done = (state_q == ST_CONV) && (cnt_q == CNT_W'(1)) && !(timer_trig && !soft_q) &&
                     mode_first_q.run && !run_clr;

  // ---------------- sequencer ----------------
  // one conversion per trigger while run stays high; upper scan channels need none
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      step_q <= 3'h0;
      soft_q <= 1'b0;
      cnt_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irq_q <= 1'b0; // single-cycle request
      if (!mode_first_q.run || run_clr) begin
        // abort at once, no result kept
        // clock gating in deep standby also relies on run being clear
        state_q <= ST_IDLE;
        step_q <= 3'h0;
        soft_q <= 1'b0;
        cnt_q <= '0;
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            state_q <= ST_WAIT;
            step_q <= 3'h0;
          end
          ST_WAIT: begin
            if (trig) begin
              state_q <= ST_CONV;
              cnt_q <= conv_len;
            end
          end
          ST_CONV: begin
            if (timer_trig && !soft_q) begin
              // restart for the newest trigger; still counted
              cnt_q <= conv_len;
              if (!last_step) begin
                step_q <= next_step;
              end
            end else if (conv_done) begin
              step_q <= next_step;
              if (last_step) begin
                // pass complete, a later trigger starts over
                irq_q <= 1'b1;
                soft_q <= 1'b0;
                state_q <= ST_WAIT;
              end else if (mode_first_q.scan && step_q >= LAST_LOWER) begin
                // upper channels follow back to back
                soft_q <= 1'b1;
                cnt_q <= conv_len;
              end else begin
                state_q <= ST_WAIT; // external triggers ignored mid-conversion
              end
            end else begin
              cnt_q <= cnt_q - CNT_W'(1);
            end
          end
          default: state_q <= ST_IDLE; // unused code
        endcase
      end
    end
  end

  // results land only on a completed conversion
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_CHANS; i++) begin
        result_q[i] <= '0;
      end
    end else if (conv_done) begin
      result_q[slot] <= adc_data_i;
    end
  end

  // channel select toward the analog mux
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      chan_sel_q <= 3'h0;
    end else begin
      chan_sel_q <= cur_chan;
    end
  end

  assign analog_channel_input_sel_o = chan_sel_q;
  assign conv_busy_o = (state_q == ST_CONV);
  assign conv_done_irq_o = irq_q;

endmodule // adc_ext_trigger_seq
`default_nettype wire

// ---- adc_seq_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
// watches bus answers and conversion pulses at the top ports
module adc_seq_chk (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_arready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic ext_conv_trigger_pin_i,
  input wire logic conv_busy_o,
  input wire logic conv_done_irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_pulse; conv_done_irq_o |=> !conv_done_irq_o; endproperty
  a_pulse: assert property (p_pulse) else $error("done pulse too long");
  property p_end; conv_done_irq_o |-> $past(conv_busy_o); endproperty
  a_end: assert property (p_end) else $error("done without conversion");
  // shortest conversion is one step of eight cycles
  property p_len; $rose(conv_busy_o) |-> conv_busy_o [*8]; endproperty
  a_len: assert property (p_len) else $error("conversion too short");
  // a rising pin edge never starts anything
  property p_rise; $rose(ext_conv_trigger_pin_i) && !conv_busy_o && !$past(conv_busy_o) |=> !conv_busy_o; endproperty
  a_rise: assert property (p_rise) else $error("rising edge started");
  property p_bhold; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o); endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o); endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_awblk; s_axi_bvalid_o |-> !s_axi_awready_o; endproperty
  a_awblk: assert property (p_awblk) else $error("write taken while answering");
  property p_arblk; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
  a_arblk: assert property (p_arblk) else $error("read taken while answering");
endmodule // adc_seq_chk
bind adc_ext_trigger_seq adc_seq_chk u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .ext_conv_trigger_pin_i(ext_conv_trigger_pin_i),
  .conv_busy_o(conv_busy_o), .conv_done_irq_o(conv_done_irq_o));
`default_nettype wire

// ---- adc_src_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// far side: trigger source and analog inputs
module adc_src_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic fire_i,
  input wire logic [6:0] salt_i,
  input wire logic [2:0] sel_i,
  output logic pin_o,
  output logic [9:0] data_o
);
  logic [2:0] low_q; // cycles left with the pin low
  // pin idles high, a request gives one falling edge
  always_ff @(posedge mclk_i) begin
    if (rst_i || fire_i) begin
      low_q <= rst_i ? 3'h0 : 3'h4;
    end else if (low_q != 3'h0) begin
      low_q <= low_q - 3'h1;
    end
  end
  assign pin_o = (low_q == 3'h0);
  // level tells channel and pass apart
  assign data_o = {sel_i, salt_i};
endmodule // adc_src_model
`default_nettype wire

// ---- test_adc_external_trigger_sequencer.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_adc_external_trigger_sequencer;
  import adc_seq_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] aw = 8'h0, ar = 8'h0;
  logic [31:0] wd = 32'h0, rdata;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, fire = 1'b0;
  logic [3:0] tm = 4'h0; // compare matches
  logic [6:0] salt = 7'h0; // marks the pass behind a result
  logic awr, wrdy, bv, arr, rv, pin, busy, irq;
  logic [1:0] bresp, rresp;
  logic [9:0] adat;
  logic [2:0] sel;
  int err_count = 0, checks_done = 0, irqs = 0;
  initial forever #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (irq === 1'b1) irqs <= irqs + 1;
  adc_ext_trigger_seq #(.RES_W(10)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .s_axi_awaddr_i(aw),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
    .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .ext_conv_trigger_pin_i(pin), .timer_match_i(tm),
    .adc_data_i(adat), .analog_channel_input_sel_o(sel), .conv_busy_o(busy), .conv_done_irq_o(irq));
  adc_src_model src (.mclk_i(mclk_i), .rst_i(rst_i), .fire_i(fire), .salt_i(salt), .sel_i(sel),
    .pin_o(pin), .data_o(adat));
  function automatic logic [31:0] ex(input int c, input logic [6:0] s); return {22'h0, 3'(c), s}; endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ta, tw;
    @(posedge mclk_i);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1; // ready for the answer from the start
    do begin
      @(negedge mclk_i);
      ta = awr;
      tw = wrdy;
      @(posedge mclk_i);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (awv && !ta || wv && !tw);
    do @(negedge mclk_i); while (bv !== 1'b1);
    chk(bresp, e);
    @(posedge mclk_i) br <= 1'b0; // answer taken at this edge
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    @(posedge mclk_i) ar <= a;
    arv <= 1'b1;
    rr <= 1'b1; // ready for the answer from the start
    do @(negedge mclk_i); while (arr !== 1'b1);
    @(posedge mclk_i) arv <= 1'b0;
    do @(negedge mclk_i); while (rv !== 1'b1);
    chk(rdata, e);
    chk(rresp, {30'h0, er});
    @(posedge mclk_i) rr <= 1'b0; // answer taken at this edge
  endtask
  // one more cycle lets a done pulse reach the counter
  task automatic idle;
    while (busy !== 1'b0) @(negedge mclk_i);
    @(negedge mclk_i);
  endtask
  task automatic tp(input logic [3:0] m);
    @(posedge mclk_i) tm <= m;
    @(posedge mclk_i) tm <= 4'h0;
    repeat (3) @(negedge mclk_i);
  endtask
  // next trigger only once the previous conversion ended
  task automatic trig;
    repeat (2) @(negedge mclk_i);
    idle;
    @(posedge mclk_i) fire <= 1'b1;
    @(posedge mclk_i) fire <= 1'b0;
    repeat (4) @(negedge mclk_i);
    idle;
  endtask
  // run cleared before each new setup
  task automatic mode(input logic [7:0] v);
    wr(OFS_MODE_FIRST, 32'h0, RESP_OKAY);
    wr(OFS_MODE_FIRST, {24'h0, v}, RESP_OKAY);
  endtask
  task automatic t_sel;
    wr(8'h44, 32'hff, RESP_SLVERR); // unmapped
    rc(8'h44, 32'h0, RESP_SLVERR);
    salt <= 7'h11;
    wr(OFS_MODE_SECOND, 32'h60, RESP_OKAY);
    wr(OFS_EXT_IRQ_MODE, {30'h0, EDGE_FALLING}, RESP_OKAY);
    mode(8'h82);
    trig;
    rc(8'h28, 32'h0);
    wr(OFS_PORT_MODE, 32'h1, RESP_OKAY);
    trig;
    rc(8'h28, ex(2, 7'h11));
    salt <= 7'h12;
    trig;
    rc(8'h28, ex(2, 7'h12));
    chk(irqs, 2);
    rc(8'h20, 32'h0);
  endtask
  task automatic t_buf4;
    salt <= 7'h21;
    mode(8'ha1);
    for (int k = 0; k < 4; k++) begin
      trig;
      chk(irqs, (k == 3) ? 3 : 2);
    end
    for (int n = 0; n < 4; n++) rc(8'h20 + 8'(4 * n), ex(1, 7'h21));
  endtask
  task automatic t_scan(input int last, input logic [6:0] s);
    int i0;
    i0 = irqs;
    salt <= s;
    mode(8'hc0 | 8'(last));
    repeat (4) trig;
    while (irqs == i0) @(negedge mclk_i);
    for (int n = 0; n < 8; n++) rc(8'h20 + 8'(4 * n), ex(n, (n <= last) ? s : 7'h31));
    chk(irqs - i0, 1);
    salt <= s + 7'h1;
    trig;
    rc(8'h20, ex(0, s + 7'h1));
  endtask
  task automatic t_abort;
    int i0;
    i0 = irqs;
    wr(OFS_MODE_SECOND, 32'h61, RESP_OKAY);
    salt <= 7'h41;
    mode(8'h80);
    @(posedge mclk_i) fire <= 1'b1;
    @(posedge mclk_i) fire <= 1'b0;
    repeat (12) @(negedge mclk_i);
    chk(busy, 1'b1);
    wr(OFS_MODE_FIRST, 32'h0, RESP_OKAY);
    repeat (20) @(negedge mclk_i);
    chk(irqs - i0, 0);
    rc(8'h20, ex(0, 7'h34));
  endtask
  task automatic t_timer;
    int i0;
    i0 = irqs;
    wr(OFS_MODE_SECOND, 32'h21, RESP_OKAY);
    salt <= 7'h51;
    mode(8'ha0);
    tp(4'h3);
    repeat (10) @(negedge mclk_i);
    tp(4'h1);
    for (int k = 0; k < 2; k++) begin
      idle;
      chk(irqs - i0, 0);
      tp(4'h4);
    end
    idle;
    chk(irqs - i0, 1);
    rc(8'h20, ex(0, 7'h34));
    for (int n = 1; n < 4; n++) rc(8'h20 + 8'(4 * n), ex(0, 7'h51));
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_sel;
    t_buf4;
    t_scan(7, 7'h31);
    t_scan(3, 7'h33);
    t_abort;
    t_timer;
    finish_test;
  end
  // cut a hang short well beyond the expected run
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    finish_test;
  end
endmodule // test_adc_external_trigger_sequencer
`default_nettype wire
